// file: dv/jnp_nvm_jtag_sva.sv
`timescale 1ns/1ps
module jnp_nvm_jtag_sva #(
  parameter int FLASH_ADDRESS_TOP_BIT = 15
) (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic o_core_reset,
  input wire logic o_prog_unlocked,
  input wire logic [15:0] o_nvm_addr,
  input wire jnp_pkg::jnp_nvm_cmd_t o_nvm_cmd
);
  // ---------
  // op checks
  // ---------
  logic last_lo;
  wire logic [3:0] op = o_nvm_cmd.op;
  wire logic is_op = op != jnp_pkg::OP_NONE;
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_arst_n);
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) last_lo <= 1'b0;
    else if (op == jnp_pkg::OP_PBUF_LO) last_lo <= 1'b1;
    else if (op == jnp_pkg::OP_PBUF_HI) last_lo <= 1'b0;
  end
  op_pulse_a: assert property (is_op |=> !is_op)
    else $error("op longer than one cycle");
  cmd_gate_a: assert property (is_op |-> o_core_reset && o_prog_unlocked)
    else $error("op while locked");
  addr_mask_a: assert property ((o_nvm_addr >> (FLASH_ADDRESS_TOP_BIT + 1)) == 16'h0)
    else $error("address above top bit");
  fuse_mask_a: assert property (op inside {jnp_pkg::OP_FUSE_EXT, jnp_pkg::OP_FUSE_HI,
    jnp_pkg::OP_FUSE_LO} |-> o_nvm_cmd.data[15:8] == ~o_nvm_cmd.data[7:0])
    else $error("fuse masks wrong");
  lock_keep_a: assert property (op == jnp_pkg::OP_LOCK |-> o_nvm_cmd.data[15:8] == 8'h00)
    else $error("lock unprogram mask set");
  byte_order_a: assert property (op == jnp_pkg::OP_PBUF_HI |-> last_lo)
    else $error("high byte without low byte");
  hi_addr_a: assert property (op == jnp_pkg::OP_PBUF_HI |-> $stable(o_nvm_addr))
    else $error("address moved on high byte");
  data_hold_a: assert property (!is_op |-> $stable(o_nvm_cmd.data))
    else $error("data changed without op");
endmodule // jnp_nvm_jtag_sva
bind jnp_nvm_jtag jnp_nvm_jtag_sva #(.FLASH_ADDRESS_TOP_BIT(FLASH_ADDRESS_TOP_BIT)) u_sva (
  .i_mclk(i_mclk), .i_arst_n(i_arst_n), .o_core_reset(o_core_reset),
  .o_prog_unlocked(o_prog_unlocked), .o_nvm_addr(o_nvm_addr), .o_nvm_cmd(o_nvm_cmd));

// file: dv/jnp_nvm_jtag_tb.sv
`timescale 1ns/1ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin bad_count++; \
  $display("[FAIL] t=%0t got=%h exp=%h", $time, a, b); end end
module jnp_nvm_jtag_tb;
  // ---------
  // bench
  // ---------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic tck, tms, tdi, tdo, oe, core_rst, unl, nvm_done;
  logic [15:0] addr, rd, ea;
  logic [7:0] d, lo;
  logic [7:0] ops [5] = '{8'h3a, 8'h3e, 8'h32, 8'h36, 8'h37};
  jnp_pkg::jnp_nvm_cmd_t cmdo, lcmd;
  jnp_pkg::jnp_fuse_t fuse;
  int seed = 82150, bad_count = 0, check_count = 0, nops = 0, busy = 0, n0;
  always #25 clk = ~clk;
  jnp_nvm_jtag #(.FLASH_ADDRESS_TOP_BIT(13)) dut (.i_mclk(clk), .i_arst_n(rst_n),
    .i_tck(tck), .i_tms(tms), .i_tdi(tdi), .i_flash_word({~addr[7:0], addr[7:0]}),
    .i_ee_byte(addr[7:0]), .i_sig_byte(addr[7:0] ^ 8'h5a), .i_cal_byte(~addr[7:0] ^ 8'h33),
    .i_fuse(fuse), .i_nvm_done(nvm_done), .o_tdo(tdo), .o_tdo_oe(oe),
    .o_core_reset(core_rst), .o_prog_unlocked(unl), .o_nvm_addr(addr), .o_nvm_cmd(cmdo));
  jnp_prog_model u_prg (.i_mclk(clk), .i_tdo(tdo), .o_tck(tck), .o_tms(tms), .o_tdi(tdi));
  // nvm stand-in: each started op completes 200 mclk later
  always @(posedge clk) begin
    if (cmdo.op != jnp_pkg::OP_NONE) begin
      lcmd <= cmdo;
      nops <= nops + 1;
      busy <= 200;
    end else if (busy > 0) busy <= busy - 1;
    nvm_done <= busy == 1;
  end
  task automatic dr(input logic [15:0] v, input int n);
    u_prg.sh(1'b0, v, n, rd);
  endtask
  task automatic ir(input logic [3:0] c);
    u_prg.sh(1'b1, {12'h0, c}, 4, rd);
  endtask
  task automatic summarize();
    $display("checks=%0d mismatches=%0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge clk);
    bad_count++;
    summarize();
  end
  initial begin
    nvm_done = 1'b0;
    fuse = $random(seed);
    repeat (12) @(posedge clk);
    #2 rst_n = 1'b1;
    repeat (3) @(posedge clk);
    #2 u_prg.tk(1'b0, 1'b0, d[0]);
    ir(jnp_pkg::IR_CORE_RST);
    dr(16'h1, 1);
    ir(jnp_pkg::IR_UNLOCK);
    dr(jnp_pkg::UNLOCK_KEY, 16);
    `CHK({core_rst, unl}, 2'b11)
    ir(jnp_pkg::IR_CMD);
    dr(16'h3180, 15);
    dr(16'h3300, 15);
    `CHK(rd, 16'h0)
    `CHK(nops, 0)
    $display("test enter done");
    dr(16'h2380, 15);
    dr(16'h3180, 15);
    `CHK(lcmd.op, jnp_pkg::OP_ERASE)
    dr(16'h3380, 15);
    `CHK(rd[9], 1'b0)
    for (int i = 0; i < 10 && !rd[9]; i++) dr(16'h3380, 15);
    `CHK(rd[9], 1'b1)
    if (!rd[9]) summarize();
    dr(16'h2304, 15);
    for (int i = 0; i < 5; i++) begin
      dr({ops[i], 8'h00}, 15);
      if (i > 0) `CHK(rd[7:0], ~fuse[39 - 8 * i -: 8])
    end
    d = $random(seed);
    dr(16'h2340, 15);
    dr({8'h13, d}, 15);
    dr(16'h3900, 15);
    `CHK(lcmd, {jnp_pkg::OP_FUSE_EXT, d, ~d})
    dr(16'h2320, 15);
    dr(16'h3100, 15);
    `CHK(lcmd, {jnp_pkg::OP_LOCK, 8'h00, ~d})
    dr(16'h2308, 15);
    for (int i = 0; i < 2; i++) begin
      d = $random(seed);
      dr({8'h03, d}, 15);
      dr(16'h3200, 15);
      dr(16'h3300, 15);
      `CHK(rd[7:0], d ^ 8'h5a)
      dr(16'h3600, 15);
      dr(16'h3700, 15);
      `CHK(rd[7:0], ~d ^ 8'h33)
    end
    $display("test fuse and id done");
    lo = $random(seed) & 8'he0;
    ea = {8'h3f, lo};
    dr(16'h2310, 15);
    dr(16'h07ff, 15);
    dr({8'h03, lo}, 15);
    `CHK(addr, ea)
    dr({8'h13, d}, 15);
    dr({8'h17, ~d}, 15);
    dr(16'h7700, 15);
    `CHK(lcmd, {jnp_pkg::OP_PBUF_WORD, ~d, d})
    dr(16'h3500, 15);
    `CHK(lcmd.op, jnp_pkg::OP_FLASH_PAGE)
    ir(jnp_pkg::IR_PLOAD);
    for (int i = 0; i < 4; i++) begin
      d = $random(seed);
      dr({8'h00, d}, 8);
    end
    `CHK(lcmd, {jnp_pkg::OP_PBUF_HI, 8'h00, d})
    `CHK(addr, ea + 16'h1)
    ir(jnp_pkg::IR_CMD);
    dr({8'h03, lo}, 15);
    ir(jnp_pkg::IR_PREAD);
    dr(16'h0, 8);
    `CHK(rd[7:0], lo)
    dr(16'h0, 8);
    `CHK(rd[7:0], ~lo)
    `CHK(addr, ea + 16'h1)
    dr(16'h0, 8);
    `CHK(rd[7:0], lo + 8'h1)
    $display("test page stream done");
    ir(jnp_pkg::IR_CMD);
    dr(16'h2300, 15);
    dr(16'h3300, 15);
    n0 = nops;
    dr(16'h3180, 15);
    `CHK(nops, n0)
    ir(jnp_pkg::IR_UNLOCK);
    dr(16'h0, 12);
    ir(jnp_pkg::IR_CORE_RST);
    dr(16'h0, 1);
    `CHK({core_rst, unl, oe}, 3'b000)
    $display("test exit done");
    summarize();
  end
endmodule // jnp_nvm_jtag_tb

// file: dv/jnp_prog_model.sv
`timescale 1ns/1ps
module jnp_prog_model (
  input wire logic i_mclk,
  input wire logic i_tdo,
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi
);
  // ---------
  // tap walker
  // ---------
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b0;
  end
  // one 400 ns tck period; tck rests low between frames
  task automatic tk(input logic t, input logic d, output logic q);
    o_tms = t;
    o_tdi = d;
    repeat (4) @(posedge i_mclk);
    #2 q = i_tdo;
    o_tck = 1'b1;
    repeat (4) @(posedge i_mclk);
    #2 o_tck = 1'b0;
  endtask
  // idle, scan, update, idle: a byte frame spans 13 tck
  task automatic sh(input logic ir, input logic [15:0] v, input int n,
    output logic [15:0] r);
    logic q;
    r = 16'h0;
    tk(1'b1, 1'b0, q);
    if (ir) tk(1'b1, 1'b0, q);
    tk(1'b0, 1'b0, q);
    tk(1'b0, 1'b0, q);
    for (int i = 0; i < n; i++) begin
      tk(i == n - 1, v[i], q);
      r[i] = q;
    end
    tk(1'b1, ~v[n - 1], q);
    tk(1'b0, v[n - 1], q);
  endtask
endmodule // jnp_prog_model

// file: hw/jnp_nvm_jtag.sv
// Function
// [R1] fuse/lock read words return extended, high, low fuse then lock bits
// [R2] signature mode, address load, read words return selected signature byte
// [R3] calibration read shares signature enter word and low address load
// [R4] calibration read words 0110110 then 0110111 return calibration byte
// [R5] no-operation enter word disables every armed programming function
// [R6] programmer may skip leading words when upper seven bits already match
// [R7] poll status bit reads 0 while an operation runs, 1 when done
// [R8] fuse write data bit 0 programs fuse, 1 unprograms it
// [R9] lock write data bit 0 programs lock bit, 1 leaves it unchanged
// [R10] fuse and lock readout returns 0 programmed, 1 unprogrammed
// [R11] address bits above implemented flash or eeprom top bit are ignored
// [R12] page load update copies byte chain to holding register, writes buffer
// [R13] page load updates alternate low then high byte, first is low
// [R14] page load pre-increments address before low bytes except the first
// [R15] page read captures alternate low then high flash byte, low first
// [R16] page read post-increments address after every high byte capture
// [R17] programmer keeps eleven test clocks between page load updates
// [R18] core hold then unlock key enables programming commands
// [R19] exit: nop, clear unlock register, release core hold
// [R20] chip erase started under command instruction, then polled
// [R21] programmer erases the chip before any flash programming
// [R22] programmer follows the word-by-word flash write sequence
// [R23] programmer loads page address with word index 0 before streaming
// [R24] commands with no function enabled are ignored and shift out zeros
`timescale 1ns/1ps
module jnp_nvm_jtag #(
  parameter int FLASH_ADDRESS_TOP_BIT = 15,
  parameter int EEPROM_ADDRESS_TOP_BIT = 10
) (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_tck,
  input wire logic i_tms,
  input wire logic i_tdi,
  input wire logic [15:0] i_flash_word,
  input wire logic [7:0] i_ee_byte,
  input wire logic [7:0] i_sig_byte,
  input wire logic [7:0] i_cal_byte,
  input wire jnp_pkg::jnp_fuse_t i_fuse,
  input wire logic i_nvm_done,
  output logic o_tdo,
  output logic o_tdo_oe,
  output logic o_core_reset,
  output logic o_prog_unlocked,
  output logic [15:0] o_nvm_addr,
  output jnp_pkg::jnp_nvm_cmd_t o_nvm_cmd
);

  localparam logic [15:0] FLASH_MASK = 16'((32'h1 << (FLASH_ADDRESS_TOP_BIT + 1)) - 32'h1);
  localparam logic [15:0] EE_MASK = 16'((32'h1 << (EEPROM_ADDRESS_TOP_BIT + 1)) - 32'h1);

  // --------------------------------------------------------------------
  // pin sampling and test clock edges
  // --------------------------------------------------------------------
  logic [2:0] pin_s;
  logic tck_d;
  logic tck_rise;
  logic tck_fall;
  logic tms;
  logic tdi;

  jnp_sync #(.W(3)) u_sync (
    .i_mclk(i_mclk),
    .i_arst_n(i_arst_n),
    .i_d({i_tck, i_tms, i_tdi}),
    .o_q(pin_s)
  );

  assign tms = pin_s[1];
  assign tdi = pin_s[0];
  assign tck_rise = pin_s[2] & ~tck_d;
  assign tck_fall = ~pin_s[2] & tck_d;

  // --------------------------------------------------------------------
  // tap controller
  // --------------------------------------------------------------------
  jnp_pkg::jnp_tap_t tap;
  jnp_pkg::jnp_tap_t next_tap;

  always_comb begin
    case (tap)
      jnp_pkg::TAP_RESET: next_tap = tms ? jnp_pkg::TAP_RESET : jnp_pkg::TAP_IDLE;
      jnp_pkg::TAP_IDLE: next_tap = tms ? jnp_pkg::TAP_SEL_DR : jnp_pkg::TAP_IDLE;
      jnp_pkg::TAP_SEL_DR: next_tap = tms ? jnp_pkg::TAP_SEL_IR : jnp_pkg::TAP_CAP_DR;
      jnp_pkg::TAP_CAP_DR: next_tap = tms ? jnp_pkg::TAP_EX1_DR : jnp_pkg::TAP_SH_DR;
      jnp_pkg::TAP_SH_DR: next_tap = tms ? jnp_pkg::TAP_EX1_DR : jnp_pkg::TAP_SH_DR;
      jnp_pkg::TAP_EX1_DR: next_tap = tms ? jnp_pkg::TAP_UP_DR : jnp_pkg::TAP_PAU_DR;
      jnp_pkg::TAP_PAU_DR: next_tap = tms ? jnp_pkg::TAP_EX2_DR : jnp_pkg::TAP_PAU_DR;
      jnp_pkg::TAP_EX2_DR: next_tap = tms ? jnp_pkg::TAP_UP_DR : jnp_pkg::TAP_SH_DR;
      jnp_pkg::TAP_UP_DR: next_tap = tms ? jnp_pkg::TAP_SEL_DR : jnp_pkg::TAP_IDLE;
      jnp_pkg::TAP_SEL_IR: next_tap = tms ? jnp_pkg::TAP_RESET : jnp_pkg::TAP_CAP_IR;
      jnp_pkg::TAP_CAP_IR: next_tap = tms ? jnp_pkg::TAP_EX1_IR : jnp_pkg::TAP_SH_IR;
      jnp_pkg::TAP_SH_IR: next_tap = tms ? jnp_pkg::TAP_EX1_IR : jnp_pkg::TAP_SH_IR;
      jnp_pkg::TAP_EX1_IR: next_tap = tms ? jnp_pkg::TAP_UP_IR : jnp_pkg::TAP_PAU_IR;
      jnp_pkg::TAP_PAU_IR: next_tap = tms ? jnp_pkg::TAP_EX2_IR : jnp_pkg::TAP_PAU_IR;
      jnp_pkg::TAP_EX2_IR: next_tap = tms ? jnp_pkg::TAP_UP_IR : jnp_pkg::TAP_SH_IR;
      jnp_pkg::TAP_UP_IR: next_tap = tms ? jnp_pkg::TAP_SEL_DR : jnp_pkg::TAP_IDLE;
      default: next_tap = jnp_pkg::TAP_RESET;
    endcase
  end

  // actions take effect at the rising test clock edge that leaves the state
  logic cap_dr;
  logic sh_dr;
  logic up_dr;
  logic cap_ir;
  logic sh_ir;
  logic up_ir;

  assign cap_dr = tck_rise & (tap == jnp_pkg::TAP_CAP_DR);
  assign sh_dr = tck_rise & (tap == jnp_pkg::TAP_SH_DR);
  assign up_dr = tck_rise & (tap == jnp_pkg::TAP_UP_DR);
  assign cap_ir = tck_rise & (tap == jnp_pkg::TAP_CAP_IR);
  assign sh_ir = tck_rise & (tap == jnp_pkg::TAP_SH_IR);
  assign up_ir = tck_rise & (tap == jnp_pkg::TAP_UP_IR);

  // --------------------------------------------------------------------
  // instruction and data scan chains
  // --------------------------------------------------------------------
  logic [3:0] ir;
  logic [3:0] ir_q;
  logic [14:0] cmd_q;
  logic [15:0] unl_q;
  logic [7:0] byte_q;
  logic [0:0] rst_q;
  logic [0:0] byp_q;
  logic sel_cmd;
  logic sel_pload;
  logic sel_pread;
  logic sel_unlock;
  logic sel_rst;
  logic sel_byp;
  logic [14:0] cmd_cap;
  logic [7:0] byte_cap;
  logic pr_cap;

  assign sel_cmd = ir == jnp_pkg::IR_CMD;
  assign sel_pload = ir == jnp_pkg::IR_PLOAD;
  assign sel_pread = ir == jnp_pkg::IR_PREAD;
  assign sel_unlock = ir == jnp_pkg::IR_UNLOCK;
  assign sel_rst = ir == jnp_pkg::IR_CORE_RST;
  assign sel_byp = ~(sel_cmd | sel_pload | sel_pread | sel_unlock | sel_rst);

  jnp_scan #(.W(jnp_pkg::IR_W)) u_ir (
    .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_cap(cap_ir), .i_shift(sh_ir),
    .i_cap_val(jnp_pkg::IR_CAPTURE), .i_tdi(tdi), .o_q(ir_q)
  );

  jnp_scan #(.W(jnp_pkg::CMD_W)) u_cmd (
    .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_cap(cap_dr & sel_cmd),
    .i_shift(sh_dr & sel_cmd), .i_cap_val(cmd_cap), .i_tdi(tdi), .o_q(cmd_q)
  );

  jnp_scan #(.W(jnp_pkg::KEY_W)) u_unlock (
    .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_cap(cap_dr & sel_unlock),
    .i_shift(sh_dr & sel_unlock), .i_cap_val(16'h0000), .i_tdi(tdi), .o_q(unl_q)
  );

  jnp_scan #(.W(jnp_pkg::BYTE_W)) u_byte (
    .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_cap(pr_cap),
    .i_shift(sh_dr & (sel_pload | sel_pread)), .i_cap_val(byte_cap), .i_tdi(tdi),
    .o_q(byte_q)
  );

  jnp_scan #(.W(1)) u_rst (
    .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_cap(cap_dr & sel_rst),
    .i_shift(sh_dr & sel_rst), .i_cap_val(o_core_reset), .i_tdi(tdi), .o_q(rst_q)
  );

  jnp_scan #(.W(1)) u_byp (
    .i_mclk(i_mclk), .i_arst_n(i_arst_n), .i_cap(cap_dr & sel_byp),
    .i_shift(sh_dr & sel_byp), .i_cap_val(1'b0), .i_tdi(tdi), .o_q(byp_q)
  );

  // --------------------------------------------------------------------
  // command decode
  // --------------------------------------------------------------------
  jnp_pkg::jnp_mode_t mode;
  jnp_pkg::jnp_mode_t next_mode;
  jnp_pkg::jnp_mode_t enter_mode;
  jnp_pkg::jnp_op_t start_op;
  jnp_pkg::jnp_op_t latch_op;
  logic [6:0] opc;
  logic [7:0] arg;
  logic prog_en;
  logic cmd_go;
  logic pl_up;
  logic ee_mode;
  logic [15:0] amask;
  logic [15:0] pc_inc;
  logic [15:0] wr_data;
  logic [7:0] data_lo;
  logic [7:0] data_hi;
  logic [7:0] rd;
  logic [7:0] rd_a;
  logic [7:0] rd_b;
  logic running;
  logic byte_hi;
  logic first_load;

  assign opc = cmd_q[14:8];
  assign arg = cmd_q[7:0];
  assign prog_en = o_prog_unlocked & o_core_reset;  // see [R18]
  assign cmd_go = up_dr & sel_cmd & prog_en;
  assign pl_up = up_dr & sel_pload & prog_en;
  assign pr_cap = cap_dr & sel_pread & prog_en;
  assign ee_mode = (mode == jnp_pkg::MODE_EE_WR) | (mode == jnp_pkg::MODE_EE_RD);
  assign amask = ee_mode ? EE_MASK : FLASH_MASK;  // see [R11]
  assign pc_inc = 16'(o_nvm_addr + 16'h0001) & amask;  // see [R11]

  // done bit sits at position 9 of the returned word, nothing when disarmed
  assign cmd_cap = (mode == jnp_pkg::MODE_NONE) ? 15'h0000 :
                   {5'h00, ~running, 1'b0, rd};  // see [R7] see [R24]
  assign byte_cap = byte_hi ? i_flash_word[15:8] : i_flash_word[7:0];  // see [R15]

  always_comb begin
    case (arg)
      jnp_pkg::ENT_ERASE: enter_mode = jnp_pkg::MODE_ERASE;
      jnp_pkg::ENT_FLASH_WR: enter_mode = jnp_pkg::MODE_FLASH_WR;
      jnp_pkg::ENT_FLASH_RD: enter_mode = jnp_pkg::MODE_FLASH_RD;
      jnp_pkg::ENT_EE_WR: enter_mode = jnp_pkg::MODE_EE_WR;
      jnp_pkg::ENT_EE_RD: enter_mode = jnp_pkg::MODE_EE_RD;
      jnp_pkg::ENT_FUSE_WR: enter_mode = jnp_pkg::MODE_FUSE_WR;
      jnp_pkg::ENT_LOCK_WR: enter_mode = jnp_pkg::MODE_LOCK_WR;
      jnp_pkg::ENT_FUSE_RD: enter_mode = jnp_pkg::MODE_FUSE_RD;
      jnp_pkg::ENT_SIG_RD: enter_mode = jnp_pkg::MODE_SIG_RD;  // see [R2] see [R3]
      default: enter_mode = jnp_pkg::MODE_NONE;  // see [R5]
    endcase
  end

  always_comb begin
    start_op = jnp_pkg::OP_NONE;
    case (mode)
      jnp_pkg::MODE_ERASE: begin
        if (opc == jnp_pkg::OPC_START_C) start_op = jnp_pkg::OP_ERASE;  // see [R20]
      end
      jnp_pkg::MODE_FLASH_WR: begin
        if (opc == jnp_pkg::OPC_START_B) start_op = jnp_pkg::OP_FLASH_PAGE;
      end
      jnp_pkg::MODE_EE_WR: begin
        if (opc == jnp_pkg::OPC_START_C) start_op = jnp_pkg::OP_EE_PAGE;
      end
      jnp_pkg::MODE_FUSE_WR: begin
        if (opc == jnp_pkg::OPC_START_A) start_op = jnp_pkg::OP_FUSE_EXT;
        if (opc == jnp_pkg::OPC_START_B) start_op = jnp_pkg::OP_FUSE_HI;
        if (opc == jnp_pkg::OPC_START_C) start_op = jnp_pkg::OP_FUSE_LO;
      end
      jnp_pkg::MODE_LOCK_WR: begin
        if (opc == jnp_pkg::OPC_START_C) start_op = jnp_pkg::OP_LOCK;
      end
      default: start_op = jnp_pkg::OP_NONE;
    endcase
  end

  assign latch_op = (mode == jnp_pkg::MODE_FLASH_WR) ? jnp_pkg::OP_PBUF_WORD :
                    (mode == jnp_pkg::MODE_EE_WR) ? jnp_pkg::OP_EE_BYTE : jnp_pkg::OP_NONE;

  // fuses carry {unprogram mask, program mask}; lock bits never unprogram
  assign wr_data = (mode == jnp_pkg::MODE_FUSE_WR) ? {data_lo, ~data_lo} :  // see [R8]
                   (mode == jnp_pkg::MODE_LOCK_WR) ? {8'h00, ~data_lo} :  // see [R9]
                   {data_hi, data_lo};

  // readouts invert programmed flags so that programmed reads as 0
  assign rd_a = (mode == jnp_pkg::MODE_FLASH_RD) ? i_flash_word[7:0] :
                (mode == jnp_pkg::MODE_EE_RD) ? i_ee_byte :
                (mode == jnp_pkg::MODE_FUSE_RD) ? ~i_fuse.lo :  // see [R1] see [R10]
                (mode == jnp_pkg::MODE_SIG_RD) ? i_sig_byte : rd;  // see [R2]
  assign rd_b = (mode == jnp_pkg::MODE_FLASH_RD) ? i_flash_word[15:8] :
                (mode == jnp_pkg::MODE_FUSE_RD) ? ~i_fuse.lock :  // see [R1] see [R10]
                (mode == jnp_pkg::MODE_SIG_RD) ? i_cal_byte : rd;  // see [R4]

  // --------------------------------------------------------------------
  // next state of the programming engine
  // --------------------------------------------------------------------
  logic [15:0] next_pc;
  logic [7:0] next_lo;
  logic [7:0] next_hi;
  logic [7:0] next_rd;
  jnp_pkg::jnp_nvm_cmd_t next_cmd;

  always_comb begin
    next_mode = mode;
    next_pc = o_nvm_addr;
    next_lo = data_lo;
    next_hi = data_hi;
    next_rd = rd;
    next_cmd.op = jnp_pkg::OP_NONE;
    next_cmd.data = o_nvm_cmd.data;
    if (!prog_en) begin
      next_mode = jnp_pkg::MODE_NONE;  // see [R19]
    end else if (cmd_go) begin
      if (opc == jnp_pkg::OPC_ENTER) begin
        next_mode = enter_mode;  // see [R5]
      end else if (mode != jnp_pkg::MODE_NONE) begin  // see [R24]
        case (opc)
          jnp_pkg::OPC_ADDR_HI: next_pc = {arg, o_nvm_addr[7:0]} & amask;  // see [R11]
          jnp_pkg::OPC_ADDR_LO: next_pc = {o_nvm_addr[15:8], arg} & amask;  // see [R3]
          jnp_pkg::OPC_DATA_LO: next_lo = arg;
          jnp_pkg::OPC_DATA_HI: next_hi = arg;
          jnp_pkg::OPC_LATCH: begin
            next_cmd.op = latch_op;
            if (latch_op != jnp_pkg::OP_NONE) next_cmd.data = {data_hi, data_lo};
          end
          jnp_pkg::OPC_START_A, jnp_pkg::OPC_START_B, jnp_pkg::OPC_START_C: begin
            next_cmd.op = start_op;
            if (start_op != jnp_pkg::OP_NONE) next_cmd.data = wr_data;
          end
          jnp_pkg::OPC_RD_A: next_rd = rd_a;
          jnp_pkg::OPC_RD_B: next_rd = rd_b;
          jnp_pkg::OPC_RD_EXT: begin
            if (mode == jnp_pkg::MODE_FUSE_RD) next_rd = ~i_fuse.ext;  // see [R1]
          end
          jnp_pkg::OPC_RD_HI: begin
            if (mode == jnp_pkg::MODE_FUSE_RD) next_rd = ~i_fuse.hi;  // see [R1]
          end
          default: next_rd = rd;
        endcase
      end
    end else if (pl_up) begin
      // chain byte goes to the holding register and page buffer at once
      next_cmd.data = {8'h00, byte_q};  // see [R12]
      next_cmd.op = byte_hi ? jnp_pkg::OP_PBUF_HI : jnp_pkg::OP_PBUF_LO;  // see [R13]
      if (!byte_hi && !first_load) next_pc = pc_inc;  // see [R14]
    end else if (pr_cap) begin
      if (byte_hi) next_pc = pc_inc;  // see [R16]
    end
  end

  // --------------------------------------------------------------------
  // registers
  // --------------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tck_d <= 1'b0;
      tap <= jnp_pkg::TAP_RESET;
    end else begin
      tck_d <= pin_s[2];
      if (tck_rise) tap <= next_tap;
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ir <= jnp_pkg::IR_BYPASS;
    end else if (tck_rise && tap == jnp_pkg::TAP_RESET) begin
      ir <= jnp_pkg::IR_BYPASS;
    end else if (up_ir) begin
      ir <= ir_q;
    end
  end

  // latched on update so the key is not live while it shifts
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_core_reset <= 1'b0;
      o_prog_unlocked <= 1'b0;
    end else if (up_dr) begin
      if (sel_rst) o_core_reset <= rst_q[0];  // see [R18] see [R19]
      if (sel_unlock) o_prog_unlocked <= unl_q == jnp_pkg::UNLOCK_KEY;  // see [R18]
    end
  end

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      mode <= jnp_pkg::MODE_NONE;
      o_nvm_addr <= 16'h0000;
      data_lo <= 8'h00;
      data_hi <= 8'h00;
      rd <= 8'h00;
      o_nvm_cmd <= '0;
    end else begin
      mode <= next_mode;
      o_nvm_addr <= next_pc;
      data_lo <= next_lo;
      data_hi <= next_hi;
      rd <= next_rd;
      o_nvm_cmd <= next_cmd;
    end
  end

  // a start in the same cycle as done wins, so no operation is lost
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      running <= 1'b0;
    end else if (cmd_go && start_op != jnp_pkg::OP_NONE) begin
      running <= 1'b1;  // see [R7]
    end else if (i_nvm_done) begin
      running <= 1'b0;
    end
  end

  // byte phase restarts whenever a new instruction is loaded
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      byte_hi <= 1'b0;
      first_load <= 1'b1;
    end else if (up_ir) begin
      byte_hi <= 1'b0;  // see [R13] see [R15]
      first_load <= 1'b1;
    end else if (pl_up || pr_cap) begin
      byte_hi <= ~byte_hi;
      first_load <= 1'b0;
    end
  end

  // --------------------------------------------------------------------
  // test data out, changes on the falling test clock edge
  // --------------------------------------------------------------------
  logic tdo_sel;

  assign tdo_sel = (tap == jnp_pkg::TAP_SH_IR) ? ir_q[0] :
                   sel_cmd ? cmd_q[0] :
                   (sel_pload | sel_pread) ? byte_q[0] :
                   sel_unlock ? unl_q[0] :
                   sel_rst ? rst_q[0] : byp_q[0];

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_tdo <= 1'b0;
      o_tdo_oe <= 1'b0;
    end else if (tck_fall) begin
      o_tdo <= tdo_sel;
      o_tdo_oe <= (tap == jnp_pkg::TAP_SH_DR) | (tap == jnp_pkg::TAP_SH_IR);
    end
  end

endmodule // jnp_nvm_jtag

// file: hw/jnp_scan.sv
`timescale 1ns/1ps
module jnp_scan #(
  parameter int W = 8
) (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic i_cap,
  input wire logic i_shift,
  input wire logic [W-1:0] i_cap_val,
  input wire logic i_tdi,
  output logic [W-1:0] o_q
);

  // lsb leaves first, new bit enters at the msb
  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      o_q <= '0;
    end else if (i_cap) begin
      o_q <= i_cap_val;
    end else if (i_shift) begin
      o_q <= W'({i_tdi, o_q} >> 1);
    end
  end

endmodule // jnp_scan

// file: hw/jnp_sync.sv
`timescale 1ns/1ps
module jnp_sync #(
  parameter int W = 1
) (
  input wire logic i_mclk,
  input wire logic i_arst_n,
  input wire logic [W-1:0] i_d,
  output logic [W-1:0] o_q
);

  logic [W-1:0] meta;

  always_ff @(posedge i_mclk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      meta <= '0;
      o_q <= '0;
    end else begin
      meta <= i_d;
      o_q <= meta;
    end
  end

endmodule // jnp_sync

// file: pkg/jnp_pkg.sv
package jnp_pkg;

  // --------------------------------------------------------------------
  // tap controller
  // --------------------------------------------------------------------
  typedef enum logic [3:0] {
    TAP_RESET = 4'h0, TAP_IDLE = 4'h1, TAP_SEL_DR = 4'h2, TAP_CAP_DR = 4'h3,
    TAP_SH_DR = 4'h4, TAP_EX1_DR = 4'h5, TAP_PAU_DR = 4'h6, TAP_EX2_DR = 4'h7,
    TAP_UP_DR = 4'h8, TAP_SEL_IR = 4'h9, TAP_CAP_IR = 4'ha, TAP_SH_IR = 4'hb,
    TAP_EX1_IR = 4'hc, TAP_PAU_IR = 4'hd, TAP_EX2_IR = 4'he, TAP_UP_IR = 4'hf
  } jnp_tap_t;

  localparam int IR_W = 4;
  localparam logic [3:0] IR_CAPTURE = 4'h1;
  localparam logic [3:0] IR_UNLOCK = 4'h4;
  localparam logic [3:0] IR_CMD = 4'h5;
  localparam logic [3:0] IR_PLOAD = 4'h6;
  localparam logic [3:0] IR_PREAD = 4'h7;
  localparam logic [3:0] IR_CORE_RST = 4'hc;
  localparam logic [3:0] IR_BYPASS = 4'hf;

  // --------------------------------------------------------------------
  // data registers and command words
  // --------------------------------------------------------------------
  localparam int CMD_W = 15;
  localparam int KEY_W = 16;
  localparam int BYTE_W = 8;
  localparam logic [15:0] UNLOCK_KEY = 16'ha370;
  localparam int PBUF_WRITE_TCK = 11;

  localparam logic [6:0] OPC_ENTER = 7'h23;
  localparam logic [6:0] OPC_ADDR_HI = 7'h07;
  localparam logic [6:0] OPC_ADDR_LO = 7'h03;
  localparam logic [6:0] OPC_DATA_LO = 7'h13;
  localparam logic [6:0] OPC_DATA_HI = 7'h17;
  localparam logic [6:0] OPC_LATCH = 7'h77;
  localparam logic [6:0] OPC_START_A = 7'h39;
  localparam logic [6:0] OPC_START_B = 7'h35;
  localparam logic [6:0] OPC_START_C = 7'h31;
  localparam logic [6:0] OPC_RD_A = 7'h32;
  localparam logic [6:0] OPC_RD_B = 7'h36;
  localparam logic [6:0] OPC_RD_EXT = 7'h3a;
  localparam logic [6:0] OPC_RD_HI = 7'h3e;

  localparam logic [7:0] ENT_NOP = 8'h00;
  localparam logic [7:0] ENT_ERASE = 8'h80;
  localparam logic [7:0] ENT_FLASH_WR = 8'h10;
  localparam logic [7:0] ENT_FLASH_RD = 8'h02;
  localparam logic [7:0] ENT_EE_WR = 8'h11;
  localparam logic [7:0] ENT_EE_RD = 8'h03;
  localparam logic [7:0] ENT_FUSE_WR = 8'h40;
  localparam logic [7:0] ENT_LOCK_WR = 8'h20;
  localparam logic [7:0] ENT_FUSE_RD = 8'h04;
  localparam logic [7:0] ENT_SIG_RD = 8'h08;

  typedef enum logic [3:0] {
    MODE_NONE = 4'h0, MODE_ERASE = 4'h1, MODE_FLASH_WR = 4'h2, MODE_FLASH_RD = 4'h3,
    MODE_EE_WR = 4'h4, MODE_EE_RD = 4'h5, MODE_FUSE_WR = 4'h6, MODE_LOCK_WR = 4'h7,
    MODE_FUSE_RD = 4'h8, MODE_SIG_RD = 4'h9
  } jnp_mode_t;

  typedef enum logic [3:0] {
    OP_NONE = 4'h0, OP_ERASE = 4'h1, OP_FLASH_PAGE = 4'h2, OP_EE_PAGE = 4'h3,
    OP_FUSE_EXT = 4'h4, OP_FUSE_HI = 4'h5, OP_FUSE_LO = 4'h6, OP_LOCK = 4'h7,
    OP_PBUF_WORD = 4'h8, OP_PBUF_LO = 4'h9, OP_PBUF_HI = 4'ha, OP_EE_BYTE = 4'hb
  } jnp_op_t;

  typedef struct packed {
    jnp_op_t op;
    logic [15:0] data;
  } jnp_nvm_cmd_t;

  // each bit is 1 when that fuse or lock bit is programmed
  typedef struct packed {
    logic [7:0] ext;
    logic [7:0] hi;
    logic [7:0] lo;
    logic [7:0] lock;
  } jnp_fuse_t;

endpackage
